// ===== logic/pci_command_status_bits.sv
// Purpose: command enables and bus-event status of one PCI function
// Assumes: config and event inputs come from PCI logic on SYS_CLK_IN
// Notes:   command at offset 04h, status at 06h in the same dword
`include "pci_cfg_params.svh"

module pci_command_status_bits
   import pci_cfg_pkg::*;
(
   input  wire logic                   SYS_CLK_IN,
   input  wire logic                   RESETN_IN,
   input  wire logic                   CE_IN,
   input  wire logic                   CFG_RD_IN,
   input  wire logic                   CFG_WR_IN,
   input  wire logic [`CFG_ADDR_W-1:0] CFG_ADDR_IN,
   input  wire logic [3:0]             CFG_BE_IN,
   input  wire logic [31:0]            CFG_WDATA_IN,
   input  wire logic                   ACCESS_REQ_IN,
   input  wire logic                   ACCESS_IS_IO_IN,
   input  wire logic                   PARITY_ERR_IN,
   input  wire logic                   SERR_DRIVEN_IN,
   input  wire logic                   MASTER_ABORT_IN,
   input  wire logic                   SPECIAL_CYCLE_IN,
   input  wire logic                   TARGET_ABORT_RCVD_IN,
   input  wire logic                   TARGET_ABORT_SENT_IN,
   input  wire logic                   PERR_DRIVEN_READ_IN,
   input  wire logic                   PERR_SEEN_WRITE_IN,
   input  wire logic                   ACTING_MASTER_IN,
   output logic [31:0]                 CFG_RDATA_OUT,
   output logic                        CFG_RVALID_OUT,
   output logic                        CLAIM_OUT,
   output logic                        MEM_SPACE_EN_OUT,
   output logic                        IO_SPACE_EN_OUT,
   output logic                        PERR_RESPONSE_OUT
);

   bank_t bank;
   bank_t next_bank;

   status_if sif ();

   function automatic logic hits_cmd_dword(input logic [`CFG_ADDR_W-1:0] addr);
      hits_cmd_dword = (addr[`CFG_ADDR_W-1:2] == `CFG_CMD_DWORD);
   endfunction

   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   assign sif.parity_err            = PARITY_ERR_IN;
   assign sif.serr_driven           = SERR_DRIVEN_IN;
   assign sif.master_abort          = MASTER_ABORT_IN;
   assign sif.special_cycle         = SPECIAL_CYCLE_IN;
   assign sif.target_abort_rcvd     = TARGET_ABORT_RCVD_IN;
   assign sif.target_abort_sent     = TARGET_ABORT_SENT_IN;
   assign sif.perr_driven_read      = PERR_DRIVEN_READ_IN;
   assign sif.perr_seen_write       = PERR_SEEN_WRITE_IN;
   assign sif.acting_master         = ACTING_MASTER_IN;
   assign sif.parity_error_response = bank.pci_access_command[`CMD_PER_BIT];

   status_word u_status (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RESETN_IN),
      .ce_in    (CE_IN),
      .sif      (sif)
   );

   always_comb begin
      logic [15:0] wmask;
      wmask = lane_mask(CFG_BE_IN[1:0]) & `CMD_RW_MASK;
      next_bank = bank;
      next_bank.rvalid = 1'b0;
      // write path: upper lanes carry status and are dropped
      if (CFG_WR_IN && hits_cmd_dword(CFG_ADDR_IN)) begin
         next_bank.pci_access_command = (bank.pci_access_command & ~wmask) |
                                        (CFG_WDATA_IN[15:0] & wmask);
      end
      // read path: unmapped dwords answer zero
      if (CFG_RD_IN) begin
         next_bank.rvalid = 1'b1;
         if (hits_cmd_dword(CFG_ADDR_IN)) begin
            next_bank.rdata = {sif.status, bank.pci_access_command};
         end else begin
            next_bank.rdata = 32'h0000_0000;
         end
      end
      // claim only for enabled spaces
      if (ACCESS_IS_IO_IN) begin
         next_bank.claim = ACCESS_REQ_IN &&
                           bank.pci_access_command[`CMD_IOS_BIT];
      end else begin
         next_bank.claim = ACCESS_REQ_IN &&
                           bank.pci_access_command[`CMD_MS_BIT];
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RESETN_IN) begin
         bank.pci_access_command <= `CMD_RESET;
         bank.rdata              <= 32'h0000_0000;
         bank.rvalid             <= 1'b0;
         bank.claim              <= 1'b0;
      end else if (CE_IN) begin
         bank <= next_bank;
      end
   end

   assign CFG_RDATA_OUT     = bank.rdata;
   assign CFG_RVALID_OUT    = bank.rvalid;
   assign CLAIM_OUT         = bank.claim;
   assign MEM_SPACE_EN_OUT  = bank.pci_access_command[`CMD_MS_BIT];
   assign IO_SPACE_EN_OUT   = bank.pci_access_command[`CMD_IOS_BIT];
   assign PERR_RESPONSE_OUT = bank.pci_access_command[`CMD_PER_BIT];

endmodule // pci_command_status_bits

// ===== logic/pci_cfg_params.svh
// Purpose: named offsets, field positions and reset values of the command/status dword
// Assumes: configuration accesses carry a byte offset and byte enables
// Notes:   definitions only
`ifndef PCI_CFG_PARAMS_SVH
`define PCI_CFG_PARAMS_SVH

`define CFG_ADDR_W        8
`define CFG_CMD_DWORD     6'h01
`define CFG_STATUS_OFFSET 8'h06
`define CFG_CAP_PTR_OFFS  8'h34

`define CMD_IOS_BIT       0
`define CMD_MS_BIT        1
`define CMD_PER_BIT       6
`define CMD_RW_MASK       16'h007f
`define CMD_RESET         16'h0000

`define ST_DPE_BIT        15
`define ST_SSE_BIT        14
`define ST_RMA_BIT        13
`define ST_RTA_BIT        12
`define ST_STA_BIT        11
`define ST_DEVSEL_HI      10
`define ST_DEVSEL_LO      9
`define ST_MASTER_DATA_PARITY_ERR_BIT       8
`define ST_FAST_BACK_TO_BACK_CAPABLE_BIT       7
`define ST_DOUBLE_SPEED_CAPABLE_BIT       5
`define ST_CL_BIT         4

`define DEVSEL_FAST       2'h0
`define DEVSEL_MEDIUM     2'h1
`define DEVSEL_SLOW       2'h2
`define DEVSEL_USED       `DEVSEL_MEDIUM
`define FAST_BACK_TO_BACK_CAPABLE_VALUE        1'h0
`define DSC_VALUE         1'h0
`define CL_VALUE          1'h1
`define FLAGS_RESET       6'h00

`endif

// ===== logic/pci_cfg_pkg.sv
// Purpose: types shared by the command/status bank
// Assumes: constants live in pci_cfg_params.svh
// Notes:   none
package pci_cfg_pkg;

   typedef struct packed {
      logic detected_parity_err;
      logic signalled_system_err;
      logic received_master_abort;
      logic received_target_abort;
      logic signalled_target_abort;
      logic master_data_parity_err;
   } flags_t;

   typedef struct packed {
      logic [15:0] pci_access_command;
      logic [31:0] rdata;
      logic        rvalid;
      logic        claim;
   } bank_t;

endpackage

// ===== logic/status_if.sv
// Purpose: bus events in, assembled status word out
// Assumes: one clock domain
// Notes:   events are single-cycle pulses or levels
interface status_if;
   logic        parity_err;
   logic        serr_driven;
   logic        master_abort;
   logic        special_cycle;
   logic        target_abort_rcvd;
   logic        target_abort_sent;
   logic        perr_driven_read;
   logic        perr_seen_write;
   logic        acting_master;
   logic        parity_error_response;
   logic [15:0] status;

   modport src (
      output parity_err, serr_driven, master_abort, special_cycle,
      output target_abort_rcvd, target_abort_sent, perr_driven_read,
      output perr_seen_write, acting_master, parity_error_response,
      input  status
   );
   modport snk (
      input  parity_err, serr_driven, master_abort, special_cycle,
      input  target_abort_rcvd, target_abort_sent, perr_driven_read,
      input  perr_seen_write, acting_master, parity_error_response,
      output status
   );
endinterface

// ===== logic/status_word.sv
// Purpose: sticky bus-event flags and the assembled status word
// Assumes: events come from logic on the same clock
// Notes:   flags clear only by reset
`include "pci_cfg_params.svh"

module status_word
   import pci_cfg_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   status_if.snk     sif
);

   flags_t flags;
   flags_t next_flags;

   always_comb begin
      next_flags = flags;
      if (sif.parity_err) begin
         next_flags.detected_parity_err = 1'b1;
      end
      if (sif.serr_driven) begin
         next_flags.signalled_system_err = 1'b1;
      end
      if (sif.master_abort && !sif.special_cycle) begin
         next_flags.received_master_abort = 1'b1;
      end
      if (sif.target_abort_rcvd) begin
         next_flags.received_target_abort = 1'b1;
      end
      if (sif.target_abort_sent) begin
         next_flags.signalled_target_abort = 1'b1;
      end
      if (sif.acting_master && sif.parity_error_response &&
          (sif.perr_driven_read || sif.perr_seen_write)) begin
         next_flags.master_data_parity_err = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flags <= `FLAGS_RESET;
      end else if (ce_in) begin
         flags <= next_flags;
      end
   end

   always_comb begin
      sif.status = 16'h0000; // reserved bits stay zero
      sif.status[`ST_DPE_BIT] = flags.detected_parity_err;
      sif.status[`ST_SSE_BIT] = flags.signalled_system_err;
      sif.status[`ST_RMA_BIT] = flags.received_master_abort;
      sif.status[`ST_RTA_BIT] = flags.received_target_abort;
      sif.status[`ST_STA_BIT] = flags.signalled_target_abort;
      sif.status[`ST_DEVSEL_HI:`ST_DEVSEL_LO] = `DEVSEL_USED;
      sif.status[`ST_MASTER_DATA_PARITY_ERR_BIT] = flags.master_data_parity_err;
      sif.status[`ST_FAST_BACK_TO_BACK_CAPABLE_BIT] = `FAST_BACK_TO_BACK_CAPABLE_VALUE;
      sif.status[`ST_DOUBLE_SPEED_CAPABLE_BIT] = `DSC_VALUE;
      sif.status[`ST_CL_BIT] = `CL_VALUE;
   end

endmodule // status_word

// ===== bench/cmd_status_chk.sv
// Purpose: port-level checks of the command/status bank
// Assumes: sees only the top-level ports, single clock
// Notes:   bound at the foot of this file
`include "pci_cfg_params.svh"

module cmd_status_chk (
   input wire logic                   SYS_CLK_IN, RESETN_IN, CE_IN, CFG_RD_IN, CFG_WR_IN,
   input wire logic [`CFG_ADDR_W-1:0] CFG_ADDR_IN,
   input wire logic [3:0]             CFG_BE_IN,
   input wire logic [31:0]            CFG_WDATA_IN, CFG_RDATA_OUT,
   input wire logic                   ACCESS_REQ_IN, ACCESS_IS_IO_IN, PARITY_ERR_IN,
   input wire logic                   CFG_RVALID_OUT, CLAIM_OUT, MEM_SPACE_EN_OUT,
   input wire logic                   IO_SPACE_EN_OUT, PERR_RESPONSE_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   wire logic rd_bank = CE_IN && CFG_RD_IN && CFG_ADDR_IN[7:2] == `CFG_CMD_DWORD;
   wire logic wr_cmd  = CE_IN && CFG_WR_IN && CFG_ADDR_IN[7:2] == `CFG_CMD_DWORD && CFG_BE_IN[0];

   AST_READ_ANSWER: assert property (CE_IN && CFG_RD_IN |=> CFG_RVALID_OUT)
      else $error("read not answered");
   AST_READ_PULSE: assert property (CE_IN && !CFG_RD_IN |=> !CFG_RVALID_OUT)
      else $error("stray read strobe");
   AST_CLAIM_TIMING: assert property (rd_bank |=> CFG_RDATA_OUT[26:25] == 2'h1)
      else $error("claim timing code wrong");
   AST_CONST_BITS: assert property (rd_bank |=> CFG_RDATA_OUT[23:16] == 8'h10)
      else $error("fixed status bits wrong");
   AST_CMD_READBACK: assert property (rd_bank |=> CFG_RDATA_OUT[15:7] == 9'h0 &&
      CFG_RDATA_OUT[6] == $past(PERR_RESPONSE_OUT) &&
      CFG_RDATA_OUT[1:0] == {$past(MEM_SPACE_EN_OUT), $past(IO_SPACE_EN_OUT)})
      else $error("command readback wrong");
   AST_CMD_WRITE: assert property (wr_cmd |=>
      {PERR_RESPONSE_OUT, MEM_SPACE_EN_OUT, IO_SPACE_EN_OUT} ==
      {$past(CFG_WDATA_IN[6]), $past(CFG_WDATA_IN[1:0])})
      else $error("command write lost");
   AST_MEM_CLAIM: assert property (CE_IN && ACCESS_REQ_IN && !ACCESS_IS_IO_IN |=>
      CLAIM_OUT == $past(MEM_SPACE_EN_OUT)) else $error("memory claim wrong");
   AST_IO_CLAIM: assert property (CE_IN && ACCESS_REQ_IN && ACCESS_IS_IO_IN |=>
      CLAIM_OUT == $past(IO_SPACE_EN_OUT)) else $error("io claim wrong");
   AST_NO_CLAIM: assert property (CE_IN && !ACCESS_REQ_IN |=> !CLAIM_OUT)
      else $error("claim without request");
   AST_PARITY_FLAG: assert property (CE_IN && PARITY_ERR_IN ##2 rd_bank |=>
      CFG_RDATA_OUT[31]) else $error("parity flag not set");
   AST_FREEZE: assert property (!CE_IN |=> $stable(CFG_RDATA_OUT) &&
      $stable({CLAIM_OUT, CFG_RVALID_OUT, MEM_SPACE_EN_OUT, IO_SPACE_EN_OUT, PERR_RESPONSE_OUT}))
      else $error("state moved while clock enable low");

   cover property (CE_IN && ACCESS_REQ_IN ##1 CLAIM_OUT);
   cover property (rd_bank ##1 CFG_RDATA_OUT[24]);
   cover property (rd_bank ##1 CFG_RDATA_OUT[29]);
   cover property (!CE_IN && CFG_WR_IN);
endmodule // cmd_status_chk

bind pci_command_status_bits cmd_status_chk u_chk (.*);

// ===== bench/host_bridge_model.sv
// Purpose: host bridge and bus agents: config cycles, target accesses, bus events
// Assumes: each call starts just after a rising edge
// Notes:   ev_out: parity, serr, mabort, special, ta rcvd, ta sent, perr rd, perr wr, master
module host_bridge_model (
   input  wire logic  clk_in,
   output logic       rd_out, wr_out, req_out, io_out,
   output logic [7:0] addr_out,
   output logic [3:0] be_out,
   output logic [31:0] data_out,
   output logic [8:0] ev_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {rd_out, wr_out, req_out, io_out, addr_out, be_out, data_out, ev_out} = '0;
   // released lines scramble so stale values cannot pass
   task automatic cyc(input logic r, w, q, io, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, input logic [8:0] e);
      rd_out   <= r;
      wr_out   <= w;
      req_out  <= q;
      io_out   <= q ? io : ~io_out;
      addr_out <= (r | w) ? a : ~addr_out;
      be_out   <= w ? b : ~be_out;
      data_out <= w ? d : ~data_out;
      ev_out   <= e;
      @(posedge clk_in);
   endtask
endmodule // host_bridge_model

// ===== bench/pci_command_status_bits_test.sv
// Purpose: random self-checking run of the command/status bank
// Assumes: host_bridge_model drives requests, clock enable dropped at random
// Notes:   mid-run resets give the sticky flags fresh chances
module pci_command_status_bits_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 0, rst_n = 0, ce = 1, rd, wr, req, is_io;
   logic        rvalid, claim, mem_en, io_en, per_en;
   logic [7:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata, rdata;
   logic [8:0]  ev, e;
   logic [15:0] r = 16'h8642;
   logic [6:0]  cmd = 7'h0;
   logic [5:0]  fl = 6'h0;
   logic        frz = 1'b0;
   int          fail_count = 0, checks = 0;
   always #2.5 clk = ~clk;
   host_bridge_model hb (.clk_in(clk), .rd_out(rd), .wr_out(wr), .req_out(req), .io_out(is_io),
      .addr_out(addr), .be_out(be), .data_out(wdata), .ev_out(ev));
   pci_command_status_bits dut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce),
      .CFG_RD_IN(rd), .CFG_WR_IN(wr), .CFG_ADDR_IN(addr), .CFG_BE_IN(be),
      .CFG_WDATA_IN(wdata), .ACCESS_REQ_IN(req), .ACCESS_IS_IO_IN(is_io),
      .PARITY_ERR_IN(ev[0]), .SERR_DRIVEN_IN(ev[1]), .MASTER_ABORT_IN(ev[2]),
      .SPECIAL_CYCLE_IN(ev[3]), .TARGET_ABORT_RCVD_IN(ev[4]), .TARGET_ABORT_SENT_IN(ev[5]),
      .PERR_DRIVEN_READ_IN(ev[6]), .PERR_SEEN_WRITE_IN(ev[7]), .ACTING_MASTER_IN(ev[8]),
      .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rvalid), .CLAIM_OUT(claim),
      .MEM_SPACE_EN_OUT(mem_en), .IO_SPACE_EN_OUT(io_en), .PERR_RESPONSE_OUT(per_en));

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [31:0] dword();
      return {fl[5:1], 2'h1, fl[0], 8'h10, 9'h0, cmd};
   endfunction
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: word %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
      end
   endtask
   task automatic idle();
      hb.cyc(0, 0, 0, 0, 8'h0, 4'h0, 32'h0, 9'h0);
   endtask
   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      ce <= 1'b0;
      repeat (n) @(posedge clk);
      rst_n <= 1'b1;
      cmd = 7'h0;
      fl = 6'h0;
      chk_bit(mem_en, 1'b0);
      chk_bit(io_en, 1'b0);
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      do_reset(16);
      ce <= 1'b1;
      hb.cyc(1, 0, 0, 0, 8'h04, 4'h0, 32'h0, 9'h0);
      idle();
      chk_word(rdata, 32'h0210_0000);
      for (int i = 0; i < 48; i++) begin
         if (i % 6 == 5) do_reset(2);
         r = lfsr(r);
         // frozen write and events must leave command and flags alone
         frz = r[9] & r[10];
         ce <= !frz;
         hb.cyc(0, 1, 0, 0, r[3] ? 8'h04 : 8'h08, r[7:4], {lfsr(r), r}, 9'h0);
         if (r[3] && r[4] && !frz) cmd = r[6:0];
         r = lfsr(r);
         e = r[8:0] & r[15:7];
         hb.cyc(0, 0, 0, 0, 8'h0, 4'h0, 32'h0, e);
         if (!frz) fl |= {e[0], e[1], e[2] & !e[3], e[4], e[5], e[8] & (e[6] | e[7]) & cmd[6]};
         r = lfsr(r);
         ce <= 1'b1;
         hb.cyc(0, 0, 1, r[0], 8'h0, 4'h0, 32'h0, 9'h0);
         hb.cyc(1, 0, 0, 0, r[1] ? 8'h04 : 8'h0c, 4'h0, 32'h0, 9'h0);
         chk_bit(claim, r[0] ? cmd[0] : cmd[1]);
         chk_bit(per_en, cmd[6]);
         idle();
         chk_bit(claim, 1'b0);
         chk_bit(rvalid, 1'b1);
         chk_word(rdata, r[1] ? dword() : 32'h0);
      end
      conclude();
   end
   initial begin
      #10000;
      fail_count++;
      conclude();
   end
endmodule // pci_command_status_bits_test
